/* File: core/irq_ctrl_pkg.sv */
// Constants for the interrupt control and status register block.
// Assumes a 16-bit register port with word indices as addresses.
package irq_ctrl_pkg;
  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [5:0] ADDR_CONTROL_ONE = 6'h00;
  localparam logic [5:0] ADDR_CONTROL_TWO = 6'h01;
  localparam logic [5:0] ADDR_FLAG_BASE = 6'h02;
  localparam logic [5:0] ADDR_ENABLE_BASE = 6'h07;
  localparam logic [5:0] ADDR_PRIO_BASE = 6'h0c;
  localparam logic [5:0] ADDR_TAKEN = 6'h1e;
  localparam logic [5:0] ADDR_STATUS_WORD = 6'h1f;
  localparam logic [5:0] ADDR_CORE_CONTROL = 6'h20;
  localparam int NUM_FLAG_REGS = 5;
  localparam int NUM_PRIO_REGS = 18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_NEST_DISABLE = 15;
  localparam int BIT_ADDR_FAULT = 3;
  localparam int BIT_STACK_FAULT = 2;
  localparam int BIT_OSC_FAULT = 1;
  localparam int BIT_ALT_TABLE = 15;
  localparam int BIT_TIMED_MASK = 14;
  localparam int NUM_EXT = 5;
  localparam int BIT_LEVEL_LO = 5;
  localparam int BIT_LEVEL_TOP = 3;
  localparam int FIRST_VECTOR = 8;
  localparam logic [2:0] LEVEL_USER_OFF = 3'h7;
  // ****************************************
  // Vector table addresses
  // ****************************************
  localparam logic [23:0] STD_TABLE_BASE = 24'h00_0014;
  localparam logic [23:0] ALT_TABLE_OFFSET = 24'h00_0100;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
endpackage

/* File: core/irq_ctrl_regs.sv */
// Interrupt controller flags, enables, priorities and CPU level.
// Assumes synchronous request pulses and a one-cycle strobe register port.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

// How it works
// - Thirty-one controller registers: two controls, five flag, five enable, eighteen priority, one taken.
// - Each source has a flag set by hardware and cleared only by software.
// - Each source has its own enable bit.
// - Each source has a three-bit priority field, eight levels.
// - On take, latch seven-bit vector and four-bit level equal to its priority.
// - Source n uses flag bit n, enable bit n, priority field n in order.
// - Low three CPU level bits sit in status word bits 7:5, writable.
// - Core control bit 3 is the level top bit; software cannot set it.
// - Level is binary 0..7, or 8..15 with top bit; 111 blocks users.
// - Top level bit set blocks all user interrupts.
// - Nesting disable makes the low level bits read-only.
// - Control one bit 15 is read/write nesting disable.
// - Trap flags: address fault bit 3, stack bit 2, oscillator bit 1.
// - Control two bit 15 selects alternate vector table, resets to zero.
// - Control two bit 14 reads one while timed masking is active.
// - Control two bits 4:0 pick edge per external input; 1 falling.
// - Unimplemented bits ignore writes and read zero.
// - Alternate table entries sit 0x100 above the standard ones.
// - At equal priority the lower vector number wins.
module irq_ctrl_regs #(
  parameter int NUM_SRC = 72
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [NUM_SRC-1:0] src_request,
  input wire logic [4:0] ext_request,
  input wire logic [4:0] ext_src_index0,
  input wire logic trap_addr_fault,
  input wire logic trap_stack_fault,
  input wire logic trap_osc_fault,
  input wire logic timed_mask_active,
  input wire logic level_top_set,
  input wire logic level_top_clear,
  input wire logic irq_ack,
  output logic irq_pending,
  output logic [6:0] pending_vector,
  output logic [23:0] vector_fetch_addr,
  output logic [3:0] cpu_priority_level,
  output logic [6:0] taken_vector_number,
  output logic [3:0] new_level_field
);
  // ****************************************
  // Storage
  // ****************************************
  localparam int NUM_BITS = irq_ctrl_pkg::NUM_FLAG_REGS * 16;
  localparam int NUM_FIELDS = irq_ctrl_pkg::NUM_PRIO_REGS * 4;

  // Refused at elaboration: every source needs a flag, an enable and a field.
  // The flag request vector also needs at least one spare bit above the sources.
  if (NUM_SRC >= NUM_BITS || NUM_SRC > NUM_FIELDS || NUM_SRC < 5) begin : g_src_range
    $error("NUM_SRC out of range");
  end

  logic [NUM_BITS-1:0] flag_q;
  logic [NUM_BITS-1:0] enable_q;
  logic [2:0] prio_q [NUM_FIELDS];
  logic nest_disable_q;
  logic [2:0] trap_q;
  logic alt_table_q;
  logic [4:0] ext_polarity_q;
  logic [4:0] ext_prev_q;
  logic [2:0] level_lo_q;
  logic level_top_q;
  logic [6:0] taken_vec_q;
  logic [3:0] taken_lvl_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [23:0] fetch_d;
  logic pend_q;
  logic [6:0] pend_vec_q;
  logic [23:0] fetch_q;
  logic [NUM_BITS-1:0] set_vec;
  logic [4:0] ext_edge;
  logic [5:0] flag_idx;
  logic [5:0] prio_idx;
  logic wr_flag;
  logic wr_enable;
  logic wr_prio;

  assign flag_idx = reg_addr - irq_ctrl_pkg::ADDR_FLAG_BASE;
  assign prio_idx = reg_addr - irq_ctrl_pkg::ADDR_PRIO_BASE;
  assign wr_flag = reg_wr && reg_addr >= irq_ctrl_pkg::ADDR_FLAG_BASE
                   && reg_addr < irq_ctrl_pkg::ADDR_ENABLE_BASE;
  assign wr_enable = reg_wr && reg_addr >= irq_ctrl_pkg::ADDR_ENABLE_BASE
                     && reg_addr < irq_ctrl_pkg::ADDR_PRIO_BASE;
  assign wr_prio = reg_wr && reg_addr >= irq_ctrl_pkg::ADDR_PRIO_BASE
                   && reg_addr < irq_ctrl_pkg::ADDR_TAKEN;

  // ****************************************
  // Request capture
  // ****************************************
  // Edge taken against the previous sample; inputs already synchronous
  always_comb begin
    for (int e = 0; e < irq_ctrl_pkg::NUM_EXT; e++) begin
      ext_edge[e] = ext_polarity_q[e] ? (ext_prev_q[e] && !ext_request[e])
                                      : (!ext_prev_q[e] && ext_request[e]);
    end
  end

  always_comb begin
    set_vec = '0;
    set_vec[NUM_SRC-1:0] = src_request;
    for (int e = 0; e < irq_ctrl_pkg::NUM_EXT; e++) begin
      if (ext_edge[e]) begin
        set_vec[ext_src_index0 + 5'(e)] = 1'b1;
      end
    end
    set_vec[NUM_BITS-1:NUM_SRC] = '0;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_prev_q <= 5'h00;
    end else begin
      ext_prev_q <= ext_request;
    end
  end

  // Set wins over a same-cycle software clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= '0;
    end else begin
      for (int b = 0; b < NUM_BITS; b++) begin
        if (b < NUM_SRC) begin
          if (set_vec[b]) begin
            flag_q[b] <= 1'b1;
          end else if (wr_flag && flag_idx == 6'(b / 16)) begin
            flag_q[b] <= reg_wdata[b % 16];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= '0;
    end else begin
      for (int b = 0; b < NUM_SRC; b++) begin
        if (wr_enable && flag_idx == 6'(b / 16) + 6'h05) begin
          enable_q[b] <= reg_wdata[b % 16];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int f = 0; f < NUM_FIELDS; f++) begin
        prio_q[f] <= 3'h0;
      end
    end else begin
      for (int f = 0; f < NUM_SRC; f++) begin
        if (wr_prio && prio_idx == 6'(f / 4)) begin
          prio_q[f] <= reg_wdata[(f % 4) * 4 +: 3];
        end
      end
    end
  end

  // ****************************************
  // Global control and CPU level
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nest_disable_q <= 1'b0;
    end else if (reg_wr && reg_addr == irq_ctrl_pkg::ADDR_CONTROL_ONE) begin
      nest_disable_q <= reg_wdata[irq_ctrl_pkg::BIT_NEST_DISABLE];
    end
  end

  // Control two: table select and edge polarity
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      alt_table_q <= 1'b0;
      ext_polarity_q <= 5'h00;
    end else if (reg_wr && reg_addr == irq_ctrl_pkg::ADDR_CONTROL_TWO) begin
      alt_table_q <= reg_wdata[irq_ctrl_pkg::BIT_ALT_TABLE];
      ext_polarity_q <= reg_wdata[4:0];
    end
  end

  logic [2:0] trap_in;
  assign trap_in = {trap_addr_fault, trap_stack_fault, trap_osc_fault};

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      trap_q <= 3'h0;
    end else if (reg_wr && reg_addr == irq_ctrl_pkg::ADDR_CONTROL_ONE) begin
      trap_q <= trap_in | reg_wdata[irq_ctrl_pkg::BIT_ADDR_FAULT:1];
    end else begin
      trap_q <= trap_q | trap_in;
    end
  end

  // Core sets the top bit on trap entry; software may only clear it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      level_top_q <= 1'b0;
    end else if (level_top_set) begin
      level_top_q <= 1'b1;
    end else if (level_top_clear || (reg_wr && reg_addr == irq_ctrl_pkg::ADDR_CORE_CONTROL
                 && !reg_wdata[irq_ctrl_pkg::BIT_LEVEL_TOP])) begin
      level_top_q <= 1'b0;
    end
  end

  // Taking an interrupt raises the level to its priority
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      level_lo_q <= 3'h0;
    end else if (irq_ack && pend_q) begin
      level_lo_q <= 3'(new_level_calc());
    end else if (reg_wr && reg_addr == irq_ctrl_pkg::ADDR_STATUS_WORD
                 && !nest_disable_q) begin
      level_lo_q <= reg_wdata[irq_ctrl_pkg::BIT_LEVEL_LO +: 3];
    end
  end

  function automatic logic [2:0] new_level_calc();
    new_level_calc = prio_q[pend_vec_q - 7'(irq_ctrl_pkg::FIRST_VECTOR)];
  endfunction

  // ****************************************
  // Arbitration
  // ****************************************
  logic [3:0] cur_level;
  logic best_hit;
  logic [2:0] best_prio;
  logic [6:0] best_vec;
  assign cur_level = {level_top_q, level_lo_q};

  // Strict greater-than keeps the lowest vector at equal priority
  always_comb begin
    best_hit = 1'b0;
    best_prio = 3'h0;
    best_vec = 7'h00;
    for (int s = 0; s < NUM_SRC; s++) begin
      if (flag_q[s] && enable_q[s] && {1'b0, prio_q[s]} > cur_level
          && (!best_hit || prio_q[s] > best_prio)) begin
        best_hit = 1'b1;
        best_prio = prio_q[s];
        best_vec = 7'(s + irq_ctrl_pkg::FIRST_VECTOR);
      end
    end
  end

  // Idle address parks on the first entry; a bare subtraction would wrap
  always_comb begin
    fetch_d = irq_ctrl_pkg::STD_TABLE_BASE;
    if (best_hit) begin
      fetch_d = irq_ctrl_pkg::STD_TABLE_BASE
                + {16'h0000, 7'(best_vec - 7'(irq_ctrl_pkg::FIRST_VECTOR)), 1'b0};
      if (alt_table_q) begin
        fetch_d = fetch_d + irq_ctrl_pkg::ALT_TABLE_OFFSET;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= best_hit && !(irq_ack && pend_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_vec_q <= 7'h00;
    end else begin
      pend_vec_q <= best_vec;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fetch_q <= irq_ctrl_pkg::STD_TABLE_BASE;
    end else begin
      fetch_q <= fetch_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      taken_vec_q <= 7'h00;
      taken_lvl_q <= 4'h0;
    end else if (irq_ack && pend_q) begin
      taken_vec_q <= pend_vec_q;
      taken_lvl_q <= {1'b0, new_level_calc()};
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Unmapped indices and unused bits fall through to zero
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_addr == irq_ctrl_pkg::ADDR_CONTROL_ONE) begin
      rdata_d = {nest_disable_q, 11'h000, trap_q, 1'b0};
    end else if (reg_addr == irq_ctrl_pkg::ADDR_CONTROL_TWO) begin
      rdata_d = {alt_table_q, timed_mask_active, 9'h000, ext_polarity_q};
    end else if (wr_flag_rd(reg_addr, irq_ctrl_pkg::ADDR_FLAG_BASE)) begin
      rdata_d = flag_q[16 * flag_idx +: 16];
    end else if (wr_flag_rd(reg_addr, irq_ctrl_pkg::ADDR_ENABLE_BASE)) begin
      rdata_d = enable_q[16 * (flag_idx - 6'h05) +: 16];
    end else if (reg_addr >= irq_ctrl_pkg::ADDR_PRIO_BASE
                 && reg_addr < irq_ctrl_pkg::ADDR_TAKEN) begin
      for (int k = 0; k < 4; k++) begin
        rdata_d[k * 4 +: 3] = prio_q[4 * prio_idx + k];
      end
    end else if (reg_addr == irq_ctrl_pkg::ADDR_TAKEN) begin
      rdata_d = {4'h0, taken_lvl_q, 1'b0, taken_vec_q};
    end else if (reg_addr == irq_ctrl_pkg::ADDR_STATUS_WORD) begin
      rdata_d = {8'h00, level_lo_q, 5'h00};
    end else if (reg_addr == irq_ctrl_pkg::ADDR_CORE_CONTROL) begin
      rdata_d = {12'h000, level_top_q, 3'h0};
    end
  end

  // Read data only moves on a read strobe and holds otherwise
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= irq_ctrl_pkg::RESET_VALUE;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  function automatic logic wr_flag_rd(input logic [5:0] a, input logic [5:0] base);
    wr_flag_rd = a >= base && a < base + 6'h05;
  endfunction

  assign reg_rdata = rdata_q;
  assign irq_pending = pend_q;
  assign pending_vector = pend_vec_q;
  assign vector_fetch_addr = fetch_q;
  assign cpu_priority_level = cur_level;
  assign taken_vector_number = taken_vec_q;
  assign new_level_field = taken_lvl_q;
endmodule

/* File: sim/irq_ctrl_sva.sv */
// Checker for the interrupt control and status registers.
// Assumes a bind to the block's top module.
`timescale 1ns/1ps
module irq_ctrl_sva (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic irq_ack,
  input wire logic level_top_set,
  input wire logic irq_pending,
  input wire logic [6:0] pending_vector,
  input wire logic [23:0] vector_fetch_addr,
  input wire logic [3:0] cpu_priority_level,
  input wire logic [6:0] taken_vector_number,
  input wire logic [3:0] new_level_field
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // Take and level
  // ****************************************
  sequence take_s;
    irq_pending && irq_ack;
  endsequence
  ack_drops_pend_a: assert property (take_s |=> !irq_pending)
    else $error("pending stays after ack");
  taken_vector_a: assert property (take_s |=> taken_vector_number == $past(pending_vector))
    else $error("taken vector wrong");
  taken_level_a: assert property (take_s |=> new_level_field == cpu_priority_level)
    else $error("taken level differs from cpu level");
  above_level_a: assert property (take_s |=> new_level_field > $past(cpu_priority_level))
    else $error("taken priority not above level");
  top_blocks_a: assert property (cpu_priority_level[3] && $past(cpu_priority_level[3])
    |-> !irq_pending)
    else $error("user interrupt with top level bit");
  top_by_core_a: assert property ($rose(cpu_priority_level[3]) |-> $past(level_top_set))
    else $error("top level bit set without core");
  // Table offset bit masked so one check fits both tables
  fetch_addr_a: assert property (irq_pending |-> (vector_fetch_addr & 24'hff_feff)
    == {16'h0000, pending_vector, 1'b0} + 24'h00_0004)
    else $error("fetch address wrong");
  vector_range_a: assert property (irq_pending |-> pending_vector >= 7'h08
    && pending_vector < 7'h50)
    else $error("pending vector out of range");
  cover property (take_s);
  cover property ($rose(cpu_priority_level[3]));
  cover property (irq_pending && vector_fetch_addr[8]);
endmodule

/* File: sim/irq_ctrl_core_model.sv */
// CPU core model that takes pending interrupts.
// Assumes the bench sets the permission and the delay.
`timescale 1ns/1ps
module irq_ctrl_core_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic irq_pending,
  input wire logic ack_allow,
  input wire logic [3:0] ack_delay,
  output logic irq_ack
);
  logic [3:0] wait_q;
  // Ack is one cycle; a fresh wait starts after each take
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 4'h0;
      irq_ack <= 1'b0;
    end else if (irq_ack || !irq_pending || !ack_allow) begin
      wait_q <= 4'h0;
      irq_ack <= 1'b0;
    end else if (wait_q >= ack_delay) begin
      irq_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

/* File: sim/interrupt_control_status_regs_bench.sv */
// Bench for the interrupt control and status registers.
// Assumes the core model answers pending interrupts.
`timescale 1ns/1ps
module interrupt_control_status_regs_bench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [71:0] src_request = '0;
  logic [4:0] ext_request = 5'h00;
  logic [2:0] trap = 3'h0;
  logic timed_mask_active = 1'b0;
  logic level_top_set = 1'b0;
  logic ack_allow = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  logic irq_ack, irq_pending;
  logic [15:0] reg_rdata, r, m;
  logic [6:0] pending_vector, taken_vector_number;
  logic [23:0] vector_fetch_addr;
  logic [3:0] cpu_priority_level, new_level_field;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 19397;
  int s, p;
  always #50 clk_sys = ~clk_sys;
  irq_ctrl_regs #(.NUM_SRC(72)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_request(src_request), .ext_request(ext_request),
    .ext_src_index0(5'h00), .trap_addr_fault(trap[2]), .trap_stack_fault(trap[1]),
    .trap_osc_fault(trap[0]), .timed_mask_active(timed_mask_active),
    .level_top_set(level_top_set), .level_top_clear(1'b0), .irq_ack(irq_ack),
    .irq_pending(irq_pending), .pending_vector(pending_vector),
    .vector_fetch_addr(vector_fetch_addr), .cpu_priority_level(cpu_priority_level),
    .taken_vector_number(taken_vector_number), .new_level_field(new_level_field));
  irq_ctrl_core_model core_u (.clk_sys(clk_sys), .rst_b(rst_b), .irq_pending(irq_pending),
    .ack_allow(ack_allow), .ack_delay(ack_delay), .irq_ack(irq_ack));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] lvl(input int v);
    return 16'(v << 5);
  endfunction
  // Sources s and s+1 share one word since s is even
  function automatic logic [15:0] prio_w(input int s, input int p);
    return 16'((p | (p << 4)) << (4 * (s % 4)));
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] mk, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk({8'h00, reg_rdata & mk}, {8'h00, e});
    @(posedge clk_sys);
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #3_000_000;
    error_cnt++;
    final_report();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk(vector_fetch_addr, 24'h00_0014);
    for (int a = 0; a < 34; a++) rdc(6'(a), (a == 32) ? 16'h0008 : 16'hffff, 16'h0000);
    wr(6'h3f, 16'hffff);
    rdc(6'h3f, 16'hffff, 16'h0000);
    wr(irq_ctrl_pkg::ADDR_CONTROL_ONE, 16'h8001);
    rdc(irq_ctrl_pkg::ADDR_CONTROL_ONE, 16'h8001, 16'h8000);
    wr(irq_ctrl_pkg::ADDR_STATUS_WORD, 16'h00e0);
    rdc(irq_ctrl_pkg::ADDR_STATUS_WORD, 16'h00e0, 16'h0000);
    wr(irq_ctrl_pkg::ADDR_CONTROL_ONE, 16'h0000);
    for (int v = 0; v < 8; v++) begin
      wr(irq_ctrl_pkg::ADDR_STATUS_WORD, lvl(v));
      rdc(irq_ctrl_pkg::ADDR_STATUS_WORD, 16'h00e0, lvl(v));
      chk({20'h0, cpu_priority_level}, 24'(v));
    end
    wr(irq_ctrl_pkg::ADDR_CORE_CONTROL, 16'hffff);
    rdc(irq_ctrl_pkg::ADDR_CORE_CONTROL, 16'h0008, 16'h0000);
    level_top_set <= 1'b1;
    @(posedge clk_sys);
    level_top_set <= 1'b0;
    rdc(irq_ctrl_pkg::ADDR_CORE_CONTROL, 16'h0008, 16'h0008);
    chk({20'h0, cpu_priority_level}, 24'h00_000f);
    wr(irq_ctrl_pkg::ADDR_CORE_CONTROL, 16'h0000);
    rdc(irq_ctrl_pkg::ADDR_CORE_CONTROL, 16'h0008, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      r = 16'($random(seed));
      timed_mask_active <= r[14] ^ r[0];
      wr(irq_ctrl_pkg::ADDR_CONTROL_TWO, r);
      rdc(irq_ctrl_pkg::ADDR_CONTROL_TWO, 16'hffff,
          (r & 16'h801f) | {1'b0, r[14] ^ r[0], 14'h0});
    end
    for (int i = 0; i < 3; i++) begin
      trap <= 3'b100 >> i;
      @(posedge clk_sys);
      trap <= 3'b000;
      rdc(irq_ctrl_pkg::ADDR_CONTROL_ONE, 16'h000e, 16'h0008 >> i);
      wr(irq_ctrl_pkg::ADDR_CONTROL_ONE, 16'h0000);
    end
    for (int pol = 0; pol < 2; pol++) begin
      wr(irq_ctrl_pkg::ADDR_CONTROL_TWO, 16'(pol));
      ext_request[0] <= pol[0];
      repeat (4) @(posedge clk_sys);
      wr(irq_ctrl_pkg::ADDR_FLAG_BASE, 16'h0000);
      ext_request[0] <= ~pol[0];
      repeat (4) @(posedge clk_sys);
      rdc(irq_ctrl_pkg::ADDR_FLAG_BASE, 16'h0001, 16'h0001);
      wr(irq_ctrl_pkg::ADDR_FLAG_BASE, 16'h0000);
      ext_request[0] <= pol[0];
      repeat (4) @(posedge clk_sys);
      rdc(irq_ctrl_pkg::ADDR_FLAG_BASE, 16'h0001, 16'h0000);
    end
    ack_allow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      s = 2 * ($unsigned($random(seed)) % 36);
      p = 1 + $unsigned($random(seed)) % 7;
      m = 16'h0003 << (s % 16);
      ack_delay <= 4'($unsigned($random(seed)) % 8);
      wr(irq_ctrl_pkg::ADDR_CONTROL_TWO, 16'(i % 2) << 15);
      wr(irq_ctrl_pkg::ADDR_STATUS_WORD, lvl(p));
      wr(irq_ctrl_pkg::ADDR_PRIO_BASE + 6'(s / 4), prio_w(s, p));
      wr(irq_ctrl_pkg::ADDR_ENABLE_BASE + 6'(s / 16), m);
      src_request[s] <= 1'b1;
      src_request[s + 1] <= 1'b1;
      @(posedge clk_sys);
      src_request <= '0;
      repeat (4) @(posedge clk_sys);
      chk({23'h0, irq_pending}, 24'h00_0000);
      wr(irq_ctrl_pkg::ADDR_STATUS_WORD, 16'h0000);
      // Longest core wait plus pipeline; a stale taken vector cannot end it early
      repeat (14) @(posedge clk_sys);
      chk({17'h0, taken_vector_number}, 24'(8 + s));
      chk({20'h0, new_level_field}, 24'(p));
      chk({20'h0, cpu_priority_level}, 24'(p));
      chk({23'h0, irq_pending}, 24'h00_0000);
      rdc(irq_ctrl_pkg::ADDR_FLAG_BASE + 6'(s / 16), m, m);
      wr(irq_ctrl_pkg::ADDR_FLAG_BASE + 6'(s / 16), 16'h0000);
      rdc(irq_ctrl_pkg::ADDR_FLAG_BASE + 6'(s / 16), m, 16'h0000);
      wr(irq_ctrl_pkg::ADDR_ENABLE_BASE + 6'(s / 16), 16'h0000);
    end
    final_report();
  end
endmodule
bind irq_ctrl_regs irq_ctrl_sva chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .irq_ack(irq_ack),
  .level_top_set(level_top_set), .irq_pending(irq_pending), .pending_vector(pending_vector),
  .vector_fetch_addr(vector_fetch_addr), .cpu_priority_level(cpu_priority_level),
  .taken_vector_number(taken_vector_number), .new_level_field(new_level_field));
